// ==== common/rspm_pkg.sv ====
package rspm_pkg;
	// ******************************
	// register offsets
	// ******************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] QUASI_PORT_DATA_OFS = 8'h0F;
	localparam logic [7:0] MULTI_PORT_DATA_OFS = 8'h10;
	localparam logic [7:0] SERIAL_PORT_CONTROL_OFS = 8'h11;
	localparam logic [7:0] IO_CONFIG_1_OFS = 8'h12;
	localparam logic [7:0] IO_CONFIG_2_OFS = 8'h13;
	localparam logic [7:0] IO_CONFIG_3_OFS = 8'h14;
	localparam logic [7:0] PULSE_OUT_B_DUTY_OFS = 8'h15;
	localparam logic [7:0] PIN_STATUS_OFS = 8'h16;
	// ******************************
	// field positions
	// ******************************
	localparam int SPC_RX_SEL_BIT = 3;
	localparam int SPC_MODE_LSB = 0;
	localparam int IO_CONFIG_1_TX_SEL_BIT = 5;
	localparam int IO_CONFIG_2_PWM_FREQ_BIT = 2;
	localparam int IO_CONFIG_3_PWM_B_SEL_BIT = 2;
	localparam int PORTB_BIT0 = 0;
	localparam int PORTB_BIT1 = 1;
	localparam int PORTA_PWM_BIT = 3;
	localparam int STAT_ICT_BIT = 0;
	localparam int STAT_PD_BIT = 1;
	localparam int STAT_RST_BIT = 2;
	localparam logic [1:0] SER_MODE_SHIFT = 2'h0;
	// ******************************
	// reset values
	// ******************************
	localparam logic [7:0] QUASI_RESET = 8'hFF;
	localparam logic PORTB0_RESET = 1'b1;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] DUTY_RESET = 8'h00;
	// ******************************
	// timing
	// ******************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int STATE_TIME_NS = 100;
	localparam int STATE_TIME_CYCLES = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRETCH_STATE_TIMES = 16;
	localparam int STRETCH_CYCLES = STRETCH_STATE_TIMES * STATE_TIME_CYCLES;
	localparam int STRETCH_CNT_W = 6;
	localparam logic [STRETCH_CNT_W-1:0] STRETCH_LAST = STRETCH_CNT_W'(STRETCH_CYCLES - 1);
	// ******************************
	// types
	// ******************************
	typedef enum logic [1:0] {
		RSPM_RST_IDLE,
		RSPM_RST_STRETCH,
		RSPM_RST_RELEASE
	} rspm_rst_e;
endpackage

// ==== logic/rspm_pulse_gen.sv ====
`timescale 1ns/1ps
module rspm_pulse_gen
	import rspm_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] duty,
	input wire logic freq_half,
	output logic pulse_out
);
	typedef struct packed {
		logic prescale;
		logic [WIDTH-1:0] count;
		logic pulse_out;
	} rspm_pg_s;

	rspm_pg_s st_reg;
	rspm_pg_s st_next;

	// ******************************
	// waveform
	// ******************************
	always_comb begin
		st_next = st_reg;
		st_next.prescale = ~st_reg.prescale;
		// frequency select halves the count rate
		if (!freq_half || st_reg.prescale) begin
			st_next.count = st_reg.count + 1'b1;
		end
		// duty compare, zero duty gives a steady low
		st_next.pulse_out = (st_reg.count < duty);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pulse_out = st_reg.pulse_out;

	// ******************************
	// checks
	// ******************************
	property p_duty_zero;
		@(posedge clock) disable iff (!rst_n)
		($past(duty) == '0) |-> !pulse_out;
	endproperty
	a_duty_zero: assert property (p_duty_zero) else $error("pulse high with zero duty");

	property p_duty_full_period;
		@(posedge clock) disable iff (!rst_n)
		(!freq_half && st_reg.count == '0) |-> ##1 (st_reg.count == WIDTH'(1));
	endproperty
	a_duty_full_period: assert property (p_duty_full_period) else $error("counter rate wrong");

	c_pulse_rise: cover property (@(posedge clock) disable iff (!rst_n) $rose(pulse_out));
endmodule

// ==== logic/rspm_pin_mux.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - on reset detect, device drives reset pin low 16 more state times.
// - external interrupt pin wakes power-down even when the interrupt is masked.
// - serial control bit 3 picks general input or serial receive on rx pin.
// - modes 1-3 rx is input; mode 0 rx is input plus open-drain output.
// - port_b_bit1 is input only, read at offset 10h.
// - port_b_bit0 is output only, written at offset 10h.
// - io_config_1 bit 5 picks port_b_bit0 or serial transmit on tx pin.
// - modes 1-3 tx carries serial data; mode 0 carries shift clock.
// - test strap low at reset rising edge enters in-circuit test mode.
// - first port bits are quasi-bidirectional, read and written at 0Fh.
// - io_config_3 bit 2 routes pulse_out_b onto port_a_bit3.
// - pulse_out_b duty from duty register, frequency from io_config_2 bit 2.
module rspm_pin_mux
	import rspm_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic core_reset_n,
	input wire logic in_circuit_test_strap_n,
	output logic in_circuit_test_mode,
	input wire logic external_irq_pin,
	input wire logic power_down_req,
	output logic power_down,
	input wire logic rx_pin_in,
	output logic rx_pin_out,
	output logic rx_pin_oe,
	output logic tx_pin_out,
	output logic ser_rxd_in,
	input wire logic ser_rxd_out,
	input wire logic ser_txd,
	input wire logic ser_shift_clk,
	output logic [1:0] serial_mode,
	input wire logic [7:0] port_a_in,
	output logic [7:0] port_a_out,
	output logic [7:0] port_a_oe
);
	typedef struct packed {
		logic rst_sync1;
		logic rst_sync2;
		logic ict_sync1;
		logic ict_sync2;
		logic irq_sync1;
		logic irq_sync2;
		logic rx_sync1;
		logic rx_sync2;
		logic [7:0] pa_sync1;
		logic [7:0] pa_sync2;
		rspm_rst_e rst_state;
		logic [STRETCH_CNT_W-1:0] stretch_cnt;
		logic reset_pin_out;
		logic reset_pin_oe;
		logic core_reset_n;
		logic ict_mode;
		logic power_down;
		logic [7:0] quasi_latch;
		logic portb0_latch;
		logic [7:0] spc;
		logic [7:0] io_config_1;
		logic [7:0] io_config_2;
		logic [7:0] io_config_3;
		logic [7:0] duty;
		logic [DATA_W-1:0] rdata;
		logic rx_pin_out;
		logic rx_pin_oe;
		logic tx_pin_out;
		logic ser_rxd_in;
		logic [7:0] port_a_out;
		logic [7:0] port_a_oe;
	} rspm_pm_s;

	rspm_pm_s st_reg;
	rspm_pm_s st_next;
	logic pulse_b;

	// ******************************
	// helpers
	// ******************************
	function automatic logic shift_mode(input logic [7:0] spc);
		shift_mode = (spc[SPC_MODE_LSB +: 2] == SER_MODE_SHIFT);
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// ******************************
	// pulse generator
	// ******************************
	rspm_pulse_gen #(
		.WIDTH(8)
	) u_pulse_b (
		.clock(clock),
		.rst_n(rst_n),
		.duty(st_reg.duty),
		.freq_half(st_reg.io_config_2[IO_CONFIG_2_PWM_FREQ_BIT]),
		.pulse_out(pulse_b)
	);

	// ******************************
	// next state
	// ******************************
	always_comb begin
		st_next = st_reg;
		// pin synchronisers, first stage feeds only the second
		st_next.rst_sync1 = reset_pin_in;
		st_next.rst_sync2 = st_reg.rst_sync1;
		st_next.ict_sync1 = in_circuit_test_strap_n;
		st_next.ict_sync2 = st_reg.ict_sync1;
		st_next.irq_sync1 = external_irq_pin;
		st_next.irq_sync2 = st_reg.irq_sync1;
		st_next.rx_sync1 = rx_pin_in;
		st_next.rx_sync2 = st_reg.rx_sync1;
		st_next.pa_sync1 = port_a_in;
		st_next.pa_sync2 = st_reg.pa_sync1;
		st_next.reset_pin_out = 1'b0;
		st_next.rx_pin_out = 1'b0;

		// reset pin handling
		case (st_reg.rst_state)
			RSPM_RST_IDLE: begin
				// one sampled low is enough, so a single state time is caught
				if (!st_reg.rst_sync2) begin
					st_next.rst_state = RSPM_RST_STRETCH;
					st_next.stretch_cnt = '0;
					st_next.reset_pin_oe = 1'b1;
					st_next.core_reset_n = 1'b0;
				end
			end
			RSPM_RST_STRETCH: begin
				st_next.stretch_cnt = st_reg.stretch_cnt + 1'b1;
				if (st_reg.stretch_cnt == STRETCH_LAST) begin
					st_next.rst_state = RSPM_RST_RELEASE;
					st_next.reset_pin_oe = 1'b0;
				end
			end
			RSPM_RST_RELEASE: begin
				// our own drive reads back low, so wait out the sync delay here
				if (st_reg.rst_sync2) begin
					st_next.rst_state = RSPM_RST_IDLE;
					st_next.core_reset_n = 1'b1;
					st_next.ict_mode = ~st_reg.ict_sync2;
				end
			end
			default: begin
				st_next.rst_state = RSPM_RST_IDLE;
			end
		endcase

		// power-down: wake has priority over a new request
		if (!st_reg.core_reset_n) begin
			st_next.power_down = 1'b0;
		end else if (st_reg.power_down && st_reg.irq_sync2) begin
			st_next.power_down = 1'b0;
		end else if (power_down_req) begin
			st_next.power_down = 1'b1;
		end

		// register writes
		if (reg_wr) begin
			if (hit(reg_addr, QUASI_PORT_DATA_OFS)) begin
				st_next.quasi_latch = reg_wdata;
			end else if (hit(reg_addr, MULTI_PORT_DATA_OFS)) begin
				st_next.portb0_latch = reg_wdata[PORTB_BIT0];
			end else if (hit(reg_addr, SERIAL_PORT_CONTROL_OFS)) begin
				st_next.spc = reg_wdata;
			end else if (hit(reg_addr, IO_CONFIG_1_OFS)) begin
				st_next.io_config_1 = reg_wdata;
			end else if (hit(reg_addr, IO_CONFIG_2_OFS)) begin
				st_next.io_config_2 = reg_wdata;
			end else if (hit(reg_addr, IO_CONFIG_3_OFS)) begin
				st_next.io_config_3 = reg_wdata;
			end else if (hit(reg_addr, PULSE_OUT_B_DUTY_OFS)) begin
				st_next.duty = reg_wdata;
			end
		end

		// register reads, data stands one cycle only
		st_next.rdata = '0;
		if (reg_rd) begin
			if (hit(reg_addr, QUASI_PORT_DATA_OFS)) begin
				st_next.rdata = st_reg.pa_sync2;
			end else if (hit(reg_addr, MULTI_PORT_DATA_OFS)) begin
				st_next.rdata[PORTB_BIT1] = st_reg.rx_sync2;
				st_next.rdata[PORTB_BIT0] = st_reg.portb0_latch;
			end else if (hit(reg_addr, SERIAL_PORT_CONTROL_OFS)) begin
				st_next.rdata = st_reg.spc;
			end else if (hit(reg_addr, IO_CONFIG_1_OFS)) begin
				st_next.rdata = st_reg.io_config_1;
			end else if (hit(reg_addr, IO_CONFIG_2_OFS)) begin
				st_next.rdata = st_reg.io_config_2;
			end else if (hit(reg_addr, IO_CONFIG_3_OFS)) begin
				st_next.rdata = st_reg.io_config_3;
			end else if (hit(reg_addr, PULSE_OUT_B_DUTY_OFS)) begin
				st_next.rdata = st_reg.duty;
			end else if (hit(reg_addr, PIN_STATUS_OFS)) begin
				st_next.rdata[STAT_ICT_BIT] = st_reg.ict_mode;
				st_next.rdata[STAT_PD_BIT] = st_reg.power_down;
				st_next.rdata[STAT_RST_BIT] = ~st_reg.core_reset_n;
			end
		end

		// receive pin: general input never drives
		if (st_reg.spc[SPC_RX_SEL_BIT]) begin
			st_next.ser_rxd_in = st_reg.rx_sync2;
			// open drain: only a low is driven, and only in shift mode
			st_next.rx_pin_oe = shift_mode(st_reg.spc) && !ser_rxd_out;
		end else begin
			// idle-high to the serial engine while it does not own the pin
			st_next.ser_rxd_in = 1'b1;
			st_next.rx_pin_oe = 1'b0;
		end

		// transmit pin
		if (st_reg.io_config_1[IO_CONFIG_1_TX_SEL_BIT]) begin
			if (shift_mode(st_reg.spc)) begin
				st_next.tx_pin_out = ser_shift_clk;
			end else begin
				st_next.tx_pin_out = ser_txd;
			end
		end else begin
			st_next.tx_pin_out = st_reg.portb0_latch;
		end

		// quasi port: a one is a released pin held up by the pull-up
		for (int i = 0; i < 8; i++) begin
			st_next.port_a_out[i] = 1'b0;
			st_next.port_a_oe[i] = ~st_reg.quasi_latch[i];
		end
		// alternate function is a full push-pull output
		if (st_reg.io_config_3[IO_CONFIG_3_PWM_B_SEL_BIT]) begin
			st_next.port_a_out[PORTA_PWM_BIT] = pulse_b;
			st_next.port_a_oe[PORTA_PWM_BIT] = 1'b1;
		end
	end

	// ******************************
	// state register
	// ******************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.rst_sync1 <= 1'b1;
			st_reg.rst_sync2 <= 1'b1;
			st_reg.ict_sync1 <= 1'b1;
			st_reg.ict_sync2 <= 1'b1;
			st_reg.rx_sync1 <= 1'b1;
			st_reg.rx_sync2 <= 1'b1;
			st_reg.rst_state <= RSPM_RST_IDLE;
			st_reg.quasi_latch <= QUASI_RESET;
			st_reg.portb0_latch <= PORTB0_RESET;
			st_reg.spc <= CFG_RESET;
			st_reg.io_config_1 <= CFG_RESET;
			st_reg.io_config_2 <= CFG_RESET;
			st_reg.io_config_3 <= CFG_RESET;
			st_reg.duty <= DUTY_RESET;
			st_reg.tx_pin_out <= PORTB0_RESET;
			st_reg.ser_rxd_in <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign reset_pin_out = st_reg.reset_pin_out;
	assign reset_pin_oe = st_reg.reset_pin_oe;
	assign core_reset_n = st_reg.core_reset_n;
	assign in_circuit_test_mode = st_reg.ict_mode;
	assign power_down = st_reg.power_down;
	assign rx_pin_out = st_reg.rx_pin_out;
	assign rx_pin_oe = st_reg.rx_pin_oe;
	assign tx_pin_out = st_reg.tx_pin_out;
	assign ser_rxd_in = st_reg.ser_rxd_in;
	assign serial_mode = st_reg.spc[SPC_MODE_LSB +: 2];
	assign port_a_out = st_reg.port_a_out;
	assign port_a_oe = st_reg.port_a_oe;

	// ******************************
	// checks
	// ******************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	property p_stretch_len;
		$rose(reset_pin_oe) |-> ##31 reset_pin_oe ##1 !reset_pin_oe;
	endproperty
	a_stretch_len: assert property (p_stretch_len) else $error("stretch length wrong");

	property p_short_pulse;
		(st_reg.rst_state == RSPM_RST_IDLE && !st_reg.rst_sync2) |=> reset_pin_oe && !core_reset_n;
	endproperty
	a_short_pulse: assert property (p_short_pulse) else $error("reset low not caught");

	property p_core_held;
		reset_pin_oe |-> !core_reset_n;
	endproperty
	a_core_held: assert property (p_core_held) else $error("core out of reset while driving");

	property p_wake;
		(power_down && st_reg.irq_sync2) |=> !power_down;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from power-down");

	property p_rx_general;
		!st_reg.spc[SPC_RX_SEL_BIT] |=> !rx_pin_oe && ser_rxd_in;
	endproperty
	a_rx_general: assert property (p_rx_general) else $error("rx pin driven as input bit");

	property p_rx_mode;
		st_reg.spc[SPC_RX_SEL_BIT] |=>
			rx_pin_oe == ($past(st_reg.spc[1:0]) == SER_MODE_SHIFT && !$past(ser_rxd_out));
	endproperty
	a_rx_mode: assert property (p_rx_mode) else $error("rx drive wrong for mode");

	property p_portb1_read;
		(reg_rd && reg_addr == MULTI_PORT_DATA_OFS) |=> reg_rdata[1] == $past(st_reg.rx_sync2);
	endproperty
	a_portb1_read: assert property (p_portb1_read) else $error("input bit read wrong");

	property p_portb0_write;
		(reg_wr && reg_addr == MULTI_PORT_DATA_OFS) ##1
			(!st_reg.io_config_1[IO_CONFIG_1_TX_SEL_BIT] && !(reg_wr && reg_addr == MULTI_PORT_DATA_OFS))
			|=> tx_pin_out == $past(reg_wdata[0], 2);
	endproperty
	a_portb0_write: assert property (p_portb0_write) else $error("output bit not on tx pin");

	property p_tx_data;
		(st_reg.io_config_1[IO_CONFIG_1_TX_SEL_BIT] && st_reg.spc[1:0] != SER_MODE_SHIFT)
			|=> tx_pin_out == $past(ser_txd);
	endproperty
	a_tx_data: assert property (p_tx_data) else $error("tx pin not serial data");

	property p_tx_clock;
		(st_reg.io_config_1[IO_CONFIG_1_TX_SEL_BIT] && st_reg.spc[1:0] == SER_MODE_SHIFT)
			|=> tx_pin_out == $past(ser_shift_clk);
	endproperty
	a_tx_clock: assert property (p_tx_clock) else $error("tx pin not shift clock");

	property p_ict;
		(st_reg.rst_state == RSPM_RST_RELEASE && st_reg.rst_sync2)
			|=> core_reset_n && in_circuit_test_mode == !$past(st_reg.ict_sync2);
	endproperty
	a_ict: assert property (p_ict) else $error("test strap not captured");

	property p_quasi;
		(reg_wr && reg_addr == QUASI_PORT_DATA_OFS) ##1
			(!(reg_wr && reg_addr == QUASI_PORT_DATA_OFS) && !st_reg.io_config_3[IO_CONFIG_3_PWM_B_SEL_BIT])
			|=> port_a_oe == ~$past(reg_wdata, 2) && port_a_out == 8'h00;
	endproperty
	a_quasi: assert property (p_quasi) else $error("quasi port drive wrong");

	property p_pwm_route;
		st_reg.io_config_3[IO_CONFIG_3_PWM_B_SEL_BIT] |=> port_a_oe[3] && port_a_out[3] == $past(pulse_b);
	endproperty
	a_pwm_route: assert property (p_pwm_route) else $error("pulse not on port bit");

	c_stretch: cover property ($fell(reset_pin_oe));
	c_wake: cover property ($fell(power_down));
	c_ict: cover property ($rose(in_circuit_test_mode));
	c_pwm: cover property (st_reg.io_config_3[IO_CONFIG_3_PWM_B_SEL_BIT] && $rose(port_a_out[3]));
endmodule

// ==== tb/rspm_board_model.sv ====
`timescale 1ns/1ps
// ******************************
// board side: reset source, strap, pull-ups
// ******************************
module rspm_board_model (
	input wire logic clock,
	input wire logic fire,
	input wire logic strap_low,
	input wire logic rx_low,
	input wire logic [7:0] port_low,
	input wire logic reset_pin_oe,
	input wire logic rx_pin_oe,
	input wire logic [7:0] port_a_out,
	input wire logic [7:0] port_a_oe,
	output logic reset_pin_level,
	output logic strap_n,
	output logic rx_level,
	output logic [7:0] port_level
);
	logic first_reg = 1'b1;
	logic [5:0] hold_reg = 6'h00;
	// first pulse long, later ones only the shortest accepted
	always @(posedge clock) begin
		if (fire) begin
			hold_reg <= first_reg ? 6'h1F : 6'h01;
			first_reg <= 1'b0;
		end else if (hold_reg != 6'h00) begin
			hold_reg <= hold_reg - 6'h01;
		end
	end
	// pulled-up lines: released reads high, never a stale value
	assign reset_pin_level = !(fire || hold_reg != 6'h00 || reset_pin_oe);
	assign strap_n = !strap_low;
	assign rx_level = !(rx_low || rx_pin_oe);
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			port_level[i] = port_a_oe[i] ? port_a_out[i] : !port_low[i];
		end
	end
endmodule

// ==== tb/reset_serial_pwm_pin_mux_tb.sv ====
`timescale 1ns/1ps
module reset_serial_pwm_pin_mux_tb;
	import rspm_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, port_a_out, port_a_oe, port_level;
	logic reg_wr = 1'b0, reg_rd = 1'b0, external_irq_pin = 1'b0, power_down_req = 1'b0;
	logic ser_rxd_out = 1'b0, ser_txd = 1'b0, ser_shift_clk = 1'b0, fire = 1'b0;
	logic strap_low = 1'b0, rx_low = 1'b0;
	logic [7:0] port_low = 8'h00;
	logic reset_pin_out, reset_pin_oe, core_reset_n, in_circuit_test_mode, power_down;
	logic rx_pin_out, rx_pin_oe, tx_pin_out, ser_rxd_in, pin_lvl, strap_n, rx_lvl;
	logic [1:0] serial_mode;
	integer seed = 69066;
	int num_errors = 0;
	int compares = 0;
	always #25 clock = ~clock;
	rspm_pin_mux rspm_pin_mux_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reset_pin_in(pin_lvl), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.core_reset_n(core_reset_n), .in_circuit_test_strap_n(strap_n),
		.in_circuit_test_mode(in_circuit_test_mode), .external_irq_pin(external_irq_pin),
		.power_down_req(power_down_req), .power_down(power_down), .rx_pin_in(rx_lvl),
		.rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_pin_out(tx_pin_out),
		.ser_rxd_in(ser_rxd_in), .ser_rxd_out(ser_rxd_out), .ser_txd(ser_txd),
		.ser_shift_clk(ser_shift_clk), .serial_mode(serial_mode), .port_a_in(port_level),
		.port_a_out(port_a_out), .port_a_oe(port_a_oe));
	rspm_board_model rspm_board_model_inst (.clock(clock), .fire(fire), .strap_low(strap_low),
		.rx_low(rx_low), .port_low(port_low), .reset_pin_oe(reset_pin_oe),
		.rx_pin_oe(rx_pin_oe), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
		.reset_pin_level(pin_lvl), .strap_n(strap_n), .rx_level(rx_lvl),
		.port_level(port_level));
	// ******************************
	// compare and report
	// ******************************
	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp, input logic got);
		check_val(what, {15'h0000, exp}, {15'h0000, got});
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// ******************************
	// register bus
	// ******************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check_val(what, {8'h00, exp}, {8'h00, reg_rdata});
	endtask
	// ******************************
	// reset pin pulse from the board
	// ******************************
	task automatic pin_reset(input logic strap);
		int n;
		@(posedge clock);
		strap_low <= strap;
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		step(1);
		check_bit("drive early", 1'b0, reset_pin_oe);
		step(1);
		check_bit("drive", 1'b1, reset_pin_oe);
		check_bit("core reset", 1'b0, core_reset_n);
		check_bit("reset level", 1'b0, reset_pin_out);
		n = 0;
		while (reset_pin_oe === 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		check_val("stretch", 16'h0020, n[15:0]);
		n = 0;
		while (core_reset_n !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		check_val("release", 16'h0003, n[15:0]);
		check_bit("test mode", strap, in_circuit_test_mode);
		$display("test pin_reset done");
	endtask
	// ******************************
	// main sequence
	// ******************************
	initial begin
		logic [7:0] d, lo;
		int hi, rises;
		logic prev;
		logic [7:0] duty[4] = '{8'h40, 8'h40, 8'h00, 8'hFF};
		int exp_hi[4] = '{256, 256, 0, 1020};
		int exp_ri[4] = '{4, 2, 0, 4};
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		step(4);
		rchk("quasi reset", QUASI_PORT_DATA_OFS, 8'hFF);
		rchk("multi reset", MULTI_PORT_DATA_OFS, 8'h03);
		rchk("unmapped", 8'h3A, 8'h00);
		check_bit("tx reset", 1'b1, tx_pin_out);
		pin_reset(1'b1);
		pin_reset(1'b0);
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			lo = 8'($random(seed));
			wr(QUASI_PORT_DATA_OFS, d);
			port_low <= lo;
			step(3);
			check_val("quasi oe", {8'h00, ~d}, {8'h00, port_a_oe});
			check_val("quasi out", 16'h0000, {8'h00, port_a_out});
			rchk("quasi read", QUASI_PORT_DATA_OFS, d & ~lo);
		end
		port_low <= 8'h00;
		wr(QUASI_PORT_DATA_OFS, 8'hFF);
		$display("test quasi done");
		wr(MULTI_PORT_DATA_OFS, 8'h00);
		step(2);
		check_bit("tx bit0 low", 1'b0, tx_pin_out);
		wr(MULTI_PORT_DATA_OFS, 8'h01);
		wr(IO_CONFIG_1_OFS, 8'h20);
		for (int m = 0; m < 4; m++) begin
			wr(SERIAL_PORT_CONTROL_OFS, 8'h08 | 8'(m));
			ser_txd <= 1'($random(seed));
			ser_shift_clk <= 1'($random(seed));
			rx_low <= 1'($random(seed));
			ser_rxd_out <= 1'($random(seed));
			step(4);
			check_val("mode", 16'(m), {14'h0000, serial_mode});
			check_bit("tx", (m == 0) ? ser_shift_clk : ser_txd, tx_pin_out);
			check_bit("rx drive", (m == 0) && !ser_rxd_out, rx_pin_oe);
			check_bit("rx level", 1'b0, rx_pin_out);
			check_bit("rx data", !(rx_low || ((m == 0) && !ser_rxd_out)), ser_rxd_in);
		end
		wr(SERIAL_PORT_CONTROL_OFS, 8'h00);
		wr(IO_CONFIG_1_OFS, 8'h00);
		rx_low <= 1'b1;
		step(4);
		check_bit("rx gp drive", 1'b0, rx_pin_oe);
		check_bit("rx gp data", 1'b1, ser_rxd_in);
		check_bit("tx gp", 1'b1, tx_pin_out);
		rchk("rx gp read", MULTI_PORT_DATA_OFS, 8'h01);
		$display("test serial done");
		wr(IO_CONFIG_3_OFS, 8'h04);
		for (int k = 0; k < 4; k++) begin
			wr(PULSE_OUT_B_DUTY_OFS, duty[k]);
			wr(IO_CONFIG_2_OFS, (k == 1) ? 8'h04 : 8'h00);
			step(4);
			check_bit("pulse oe", 1'b1, port_a_oe[3]);
			hi = 0;
			rises = 0;
			prev = port_a_out[3];
			repeat (1024) begin
				step(1);
				hi += int'(port_a_out[3] === 1'b1);
				rises += int'(port_a_out[3] === 1'b1 && prev === 1'b0);
				prev = port_a_out[3];
			end
			check_val("pulse high", 16'(exp_hi[k]), 16'(hi));
			check_val("pulse rises", 16'(exp_ri[k]), 16'(rises));
		end
		$display("test pulse done");
		@(posedge clock);
		power_down_req <= 1'b1;
		@(posedge clock);
		power_down_req <= 1'b0;
		step(1);
		check_bit("sleep", 1'b1, power_down);
		rchk("status", PIN_STATUS_OFS, 8'h02);
		@(posedge clock);
		external_irq_pin <= 1'b1;
		step(5);
		check_bit("wake", 1'b0, power_down);
		external_irq_pin <= 1'b0;
		$display("test power_down done");
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		print_verdict();
	end
endmodule
